// ---- hw/rtc_calendar.sv ----
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module rtc_calendar
(
  input  wire logic        clk_in,        // 50 MHz clock
  input  wire logic        resetn_in,     // Async reset, active low
  input  wire logic [16:0] addr_in,       // Register byte address
  input  wire logic [7:0]  wdata_in,      // Write data
  input  wire logic        wr_in,         // Write strobe
  input  wire logic        rd_in,         // Read strobe
  input  wire logic        day_tick_in,   // One-cycle midnight pulse
  output logic      [7:0]  rdata_out,     // Read data, cycle after rd_in
  output logic      [7:0]  year_out,      // Current year
  output logic      [7:0]  month_out,     // Current month
  output logic      [7:0]  date_out,      // Current date
  output logic      [7:0]  dow_out        // Current day of week
);

  rtc_cal_pkg::cal_state_t state_reg;
  rtc_cal_pkg::cal_state_t state_next;

  logic [7:0] adv_year;
  logic [7:0] adv_month;
  logic [7:0] adv_date;
  logic [7:0] adv_dow;

  // Day roll-over arithmetic
  calendar_advance u_advance
  (
    .year_in   (state_reg.year),
    .month_in  (state_reg.month),
    .date_in   (state_reg.date),
    .dow_in    (state_reg.dow),
    .year_out  (adv_year),
    .month_out (adv_month),
    .date_out  (adv_date),
    .dow_out   (adv_dow)
  );

  // Day advance, then software writes take precedence
  always_comb
  begin
    state_next = state_reg;
    if (day_tick_in)
    begin
      state_next.year  = adv_year;
      state_next.month = adv_month;
      state_next.date  = adv_date;
      state_next.dow   = adv_dow;
    end
    if (wr_in)
    begin
      unique case (addr_in)
        rtc_cal_pkg::OFF_YEAR:
          state_next.year = wdata_in & rtc_cal_pkg::MASK_YEAR;
        rtc_cal_pkg::OFF_MONTH:
          state_next.month = wdata_in & rtc_cal_pkg::MASK_MONTH;
        rtc_cal_pkg::OFF_DATE_OF_MONTH:
          state_next.date = wdata_in & rtc_cal_pkg::MASK_DATE;
        rtc_cal_pkg::OFF_DAY_OF_WEEK:
          state_next.dow = wdata_in & rtc_cal_pkg::MASK_DOW;
        default:
          state_next = state_next;
      endcase
    end
    // Read data captured for the following cycle
    if (rd_in)
    begin
      unique case (addr_in)
        rtc_cal_pkg::OFF_YEAR:          state_next.rdata = state_reg.year;
        rtc_cal_pkg::OFF_MONTH:         state_next.rdata = state_reg.month;
        rtc_cal_pkg::OFF_DATE_OF_MONTH: state_next.rdata = state_reg.date;
        rtc_cal_pkg::OFF_DAY_OF_WEEK:   state_next.rdata = state_reg.dow;
        default: state_next.rdata = rtc_cal_pkg::READ_UNMAPPED;
      endcase
    end
    else
      state_next.rdata = rtc_cal_pkg::READ_UNMAPPED;
  end

  // State register
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state_reg.year  <= rtc_cal_pkg::RST_YEAR;
      state_reg.month <= rtc_cal_pkg::RST_MONTH;
      state_reg.date  <= rtc_cal_pkg::RST_DATE;
      state_reg.dow   <= rtc_cal_pkg::RST_DOW;
      state_reg.rdata <= rtc_cal_pkg::READ_UNMAPPED;
    end
    else
      state_reg <= state_next;
  end

  // Outputs straight from flip-flops
  assign rdata_out = state_reg.rdata;
  assign year_out  = state_reg.year;
  assign month_out = state_reg.month;
  assign date_out  = state_reg.date;
  assign dow_out   = state_reg.dow;

endmodule // rtc_calendar

// ---- include/rtc_cal_pkg.sv ----
package rtc_cal_pkg;

  // Register bus geometry
  localparam int unsigned ADDR_W = 17;
  localparam int unsigned DATA_W = 8;

  // Register offsets
  localparam logic [16:0] OFF_DAY_OF_WEEK  = 17'h1fffc;
  localparam logic [16:0] OFF_DATE_OF_MONTH = 17'h1fffd;
  localparam logic [16:0] OFF_MONTH        = 17'h1fffe;
  localparam logic [16:0] OFF_YEAR         = 17'h1ffff;

  // Implemented bits of each register, the rest read as zero
  localparam logic [7:0] MASK_YEAR  = 8'hff;
  localparam logic [7:0] MASK_MONTH = 8'h1f;
  localparam logic [7:0] MASK_DATE  = 8'h3f;
  localparam logic [7:0] MASK_DOW   = 8'h07;

  // Reset values
  localparam logic [7:0] RST_YEAR  = 8'h00;
  localparam logic [7:0] RST_MONTH = 8'h01;
  localparam logic [7:0] RST_DATE  = 8'h01;
  localparam logic [7:0] RST_DOW   = 8'h01;

  // Calendar limits in packed BCD
  localparam logic [7:0] FIRST_DAY    = 8'h01;
  localparam logic [7:0] FIRST_MONTH  = 8'h01;
  localparam logic [7:0] LAST_MONTH   = 8'h12;
  localparam logic [7:0] LAST_YEAR    = 8'h99;
  localparam logic [7:0] FIRST_YEAR   = 8'h00;
  localparam logic [7:0] LAST_DOW     = 8'h07;
  localparam logic [7:0] FEBRUARY     = 8'h02;
  localparam logic [7:0] DAYS_LONG    = 8'h31;
  localparam logic [7:0] DAYS_SHORT   = 8'h30;
  localparam logic [7:0] DAYS_FEB     = 8'h28;
  localparam logic [7:0] DAYS_FEB_LEAP = 8'h29;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // Whole state of the calendar block
  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] dow;
    logic [7:0] rdata;
  } cal_state_t;

endpackage

// ---- hw/calendar_advance.sv ----
`timescale 1ns/1ps
// Next calendar day in packed BCD, purely combinational
module calendar_advance
(
  input  wire logic [7:0] year_in,        // Current year, BCD 00-99
  input  wire logic [7:0] month_in,       // Current month, BCD 01-12
  input  wire logic [7:0] date_in,        // Current date, BCD 01-31
  input  wire logic [7:0] dow_in,         // Current day of week 1-7
  output logic      [7:0] year_out,       // Year after one day
  output logic      [7:0] month_out,      // Month after one day
  output logic      [7:0] date_out,       // Date after one day
  output logic      [7:0] dow_out         // Day of week after one day
);

  // One step of a two digit BCD counter, nibbles 0 to 9
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9)
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    else
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
  endfunction

  // Year divisible by four, 00 counted as leap
  function automatic logic is_leap(input logic [7:0] y);
    if (y[4])
      is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    else
      is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) ||
                (y[3:0] == 4'h8);
  endfunction

  // Last date of a month, February follows the year
  function automatic logic [7:0] last_day(input logic [7:0] m,
                                          input logic [7:0] y);
    unique case (m)
      rtc_cal_pkg::FEBRUARY:
        last_day = is_leap(y) ? rtc_cal_pkg::DAYS_FEB_LEAP
                              : rtc_cal_pkg::DAYS_FEB;
      8'h04, 8'h06, 8'h09, 8'h11:
        last_day = rtc_cal_pkg::DAYS_SHORT;
      default:
        last_day = rtc_cal_pkg::DAYS_LONG;
    endcase
  endfunction

  logic month_end;
  logic year_end;

  // Date, month and year roll-over chain
  always_comb
  begin
    month_end = (date_in == last_day(month_in, year_in));
    year_end  = month_end && (month_in == rtc_cal_pkg::LAST_MONTH);
    date_out  = month_end ? rtc_cal_pkg::FIRST_DAY
                          : bcd_inc(date_in);
    month_out = month_in;
    if (month_end)
      month_out = year_end ? rtc_cal_pkg::FIRST_MONTH
                           : bcd_inc(month_in);
    year_out = year_in;
    if (year_end)
      year_out = (year_in == rtc_cal_pkg::LAST_YEAR)
                 ? rtc_cal_pkg::FIRST_YEAR
                 : bcd_inc(year_in);
    dow_out = (dow_in == rtc_cal_pkg::LAST_DOW) ? rtc_cal_pkg::RST_DOW
                                                : bcd_inc(dow_in);
  end

endmodule // calendar_advance

// ---- dv/host_bus_model.sv ----
`timescale 1ns/1ps
// Host side of the register port
module host_bus_model
(
  input  wire logic        clk_in,    // Clock
  input  wire logic [7:0]  rdata_in,  // Read data
  output logic      [16:0] addr_out,  // Address
  output logic      [7:0]  wdata_out, // Write data
  output logic             wr_out,    // Write strobe
  output logic             rd_out     // Read strobe
);
  // Idle bus at time zero
  initial
  begin
    {addr_out, wdata_out, wr_out, rd_out} = '0;
  end
  // One strobe cycle; read data taken mid-cycle while it stands
  task automatic xfer(input logic w, input logic [16:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= w;
    rd_out <= !w;
    @(posedge clk_in);
    wr_out <= 1'b0;
    rd_out <= 1'b0;
    wdata_out <= ~d;
    @(negedge clk_in);
    q = rdata_in;
  endtask
endmodule // host_bus_model

// ---- dv/rtc_calendar_properties.sv ----
`timescale 1ns/1ps
// Carry checks on the calendar outputs
module rtc_calendar_properties
(
  input wire logic       clk_in,      // Clock
  input wire logic       resetn_in,   // Reset
  input wire logic       wr_in,       // Write
  input wire logic       day_tick_in, // Day pulse
  input wire logic [7:0] year_out,    // Year
  input wire logic [7:0] month_out,   // Month
  input wire logic [7:0] date_out     // Date
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // Day step with no write beside it
  wire        st  = day_tick_in && !wr_in;
  wire [23:0] ymd = {year_out, month_out, date_out};
  a_year_wrap: assert property (st && ymd == 24'h991231
    |=> ymd == 24'h000101) else $error("year wrap wrong");
  a_month_wrap: assert property (st && ymd == 24'h231231
    |=> ymd == 24'h240101) else $error("month wrap wrong");
  a_date_carry: assert property (st && date_out == 8'h09
    |=> date_out == 8'h10) else $error("date carry wrong");
  a_feb_leap: assert property (st && ymd == 24'h240228
    |=> ymd == 24'h240229) else $error("leap day missing");
  a_month_step: assert property (st && ymd == 24'h210930
    |=> ymd == 24'h211001) else $error("month step wrong");
endmodule // rtc_calendar_properties
bind rtc_calendar rtc_calendar_properties u_props (.clk_in(clk_in),
  .resetn_in(resetn_in), .wr_in(wr_in), .day_tick_in(day_tick_in),
  .year_out(year_out), .month_out(month_out), .date_out(date_out));

// ---- dv/test_rtc_calendar.sv ----
`timescale 1ns/1ps
// Self-checking bench for the calendar block
module test_rtc_calendar;
  logic        clk_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic        day_tick_in = 1'b0;
  logic        wr, rd;
  logic [16:0] addr;
  logic [7:0]  wd, rdat, yr, mo, dt, dw, q;
  int          err_total = 0;
  int          num_checks = 0;
  int          seed = 73534;
  int          y, m, d, w, i, k, last;
  int          sy[5] = '{99, 24, 23, 23, 21};
  int          sm[5] = '{12, 2, 2, 12, 9};
  int          sd[5] = '{31, 28, 28, 31, 30};
  // Clock of 20 ns period
  always #10 clk_in = ~clk_in;
  rtc_calendar u_dut (.clk_in(clk_in), .resetn_in(resetn_in),
    .addr_in(addr), .wdata_in(wd), .wr_in(wr), .rd_in(rd),
    .day_tick_in(day_tick_in), .rdata_out(rdat), .year_out(yr),
    .month_out(mo), .date_out(dt), .dow_out(dw));
  host_bus_model u_host (.clk_in(clk_in), .rdata_in(rdat),
    .addr_out(addr), .wdata_out(wd), .wr_out(wr), .rd_out(rd));
  function automatic logic [7:0] bcd(input int v);
    return 8'((v / 10) * 16 + v % 10);
  endfunction
  // Compare and count
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("mismatch %0t: saw %h want %h", $time, s, e);
    end
  endtask
  // Write all registers, or read and compare them and an unmapped place
  task automatic regs(input logic wn);
    logic [7:0] e[5];
    e = '{8'(w), bcd(d), bcd(m), bcd(y), 8'h00};
    for (int j = 0; j < 5; j++)
    begin
      u_host.xfer(wn, (j < 4) ? 17'h1fffc + 17'(j) : 17'h1fff0, e[j], q);
      if (!wn) chk(q, e[j]);
    end
  endtask
  // One day pulse, model step, compare outputs
  task automatic tick();
    @(posedge clk_in);
    day_tick_in <= 1'b1;
    @(posedge clk_in);
    day_tick_in <= 1'b0;
    last = (m == 2) ? 28 + (y % 4 == 0) : 30 + (m + m / 8) % 2;
    w = w % 7 + 1;
    d = (d < last) ? d + 1 : 1;
    if (d == 1) m = m % 12 + 1;
    if (d == 1 && m == 1) y = (y + 1) % 100;
    #1;
    chk({yr, mo, dt, dw}, {bcd(y), bcd(m), bcd(d), 8'(w)});
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Reset, then edge dates and one random date with a long run
  initial
  begin
    repeat (20) @(posedge clk_in);
    resetn_in <= 1'b1;
    {y, m, d, w} = {32'd0, 32'd1, 32'd1, 32'd1};
    regs(1'b0);
    for (i = 0; i < 6; i++)
    begin
      y = (i < 5) ? sy[i] : {$random(seed)} % 100;
      m = (i < 5) ? sm[i] : {$random(seed)} % 12 + 1;
      d = (i < 5) ? sd[i] : {$random(seed)} % 28 + 1;
      w = {$random(seed)} % 7 + 1;
      regs(1'b1);
      regs(1'b0);
      for (k = 0; k < ((i < 5) ? 2 : 400); k++) tick();
      regs(1'b0);
    end
    // Reserved month bits dropped; read data stands one cycle only
    u_host.xfer(1'b1, 17'h1fffe, 8'hff, q);
    u_host.xfer(1'b0, 17'h1fffe, 8'h00, q);
    chk(q, 8'h1f);
    @(negedge clk_in);
    chk(rdat, 8'h00);
    test_done();
  end
  // Cut a hang short well after the expected run
  initial
  begin
    #200000;
    err_total++;
    test_done();
  end
endmodule // test_rtc_calendar
